// >>> inc/acst_pkg.sv
package acst_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ACC_W = 40;
    localparam int ADDR_W = 24;
    localparam int REP_W = 8;
    localparam int NUM_ACC = 4;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDRX = 8'h04;
    localparam logic [7:0] OFF_ADDRY = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_LEG = 0;
    localparam int CTRL_SST = 1;
    localparam int CTRL_SXM = 2;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ACC_LSB = 3;
    localparam int CMD_UNS = 5;
    localparam int CMD_SAT = 6;
    localparam int CMD_REP_LSB = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_OVF = 1;
    localparam int STAT_BAD = 2;
    localparam int STAT_CNT_LSB = 8;

    // ----------------------------------------
    // clamp values and write constants
    // ----------------------------------------
    localparam logic [ACC_W-1:0] SAT_UNS = 40'h00_FFFF_FFFF;
    localparam logic [ACC_W-1:0] SAT_POS = 40'h00_7FFF_FFFF;
    localparam logic [ACC_W-1:0] SAT_NEG = 40'hFF_8000_0000;
    localparam logic [1:0] BE_WORD = 2'h3;
    localparam logic [1:0] BE_HI = 2'h2;
    localparam logic [1:0] BE_LO = 2'h1;
    localparam logic [ADDR_W-1:0] STEP_ONE = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP_TWO = 24'h000002;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        OP_WORD = 3'h0, OP_HIBYTE = 3'h1, OP_LOBYTE = 3'h2, OP_LONG = 3'h3,
        OP_SATLONG = 3'h4, OP_DUAL = 3'h5, OP_PAIRHI = 3'h6, OP_PAIRLO = 3'h7
    } acst_op_type;

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} acst_st_type;

    typedef logic [NUM_ACC-1:0][ACC_W-1:0] acst_accs_type;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [15:0] data;
        logic [1:0] be;
    } acst_mem_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } acst_apb_req_type;

    typedef struct packed {
        acst_st_type st;
        logic legacy;
        logic store_saturate_enable;
        logic sign_extension_mode;
        logic [ADDR_W-1:0] addr_x;
        logic [ADDR_W-1:0] addr_y;
        acst_op_type op;
        logic [1:0] acc;
        logic uns;
        logic sat;
        logic [REP_W-1:0] rep;
        logic ovf;
        logic bad;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        acst_mem_type mem_a;
        acst_mem_type mem_b;
    } acst_state_type;
endpackage

// >>> verilog/acst_sat_unit.sv
`timescale 1ns/1ps
module acst_sat_unit (
    input wire logic [acst_pkg::ACC_W-1:0] acc_i,
    input wire logic uns_i,
    input wire logic sat_i,
    input wire logic legacy_i,
    input wire logic sst_i,
    input wire logic sign_extension_mode_i,
    output logic [acst_pkg::ACC_W-1:0] res_o,
    output logic ovf_o
);
    import acst_pkg::*;

    logic uns_eff;
    logic sat_eff;
    logic sign_in;

    // ----------------------------------------
    // qualifier forcing
    // ----------------------------------------
    // legacy with sst forces saturation; without sign_extension_mode also unsigned
    always_comb begin
        uns_eff = uns_i | (legacy_i & sst_i & ~sign_extension_mode_i);
        sat_eff = sat_i | (legacy_i & sst_i);
    end

    // ----------------------------------------
    // overflow check and clamp
    // ----------------------------------------
    // upper bits must match the input sign, or be zero when unsigned
    always_comb begin
        sign_in = acc_i[ACC_W-1];
        if (uns_eff) begin
            ovf_o = |acc_i[ACC_W-1:32];
        end else begin
            ovf_o = acc_i[ACC_W-1:31] != {9{sign_in}};
        end
        res_o = acc_i;
        if (sat_eff && ovf_o) begin
            if (uns_eff) begin
                res_o = SAT_UNS;
            end else if (sign_in) begin
                res_o = SAT_NEG;
            end else begin
                res_o = SAT_POS;
            end
        end
    end
endmodule

// >>> verilog/acst_store_dp.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - qualifiers optional unless legacy and sst set
// - unsigned qualifier selects unsigned operand treatment
// - unsigned overflow clamps to 00FFFFFFFF
// - signed overflow clamps to 007FFFFFFF or FF80000000
// - saturating long store writes bits 31-0
// - saturating long store passes the shifter unit
// - legacy overflow compares input sign with msbs
// - legacy, sst, no sign_extension_mode force saturate unsigned
// - dual store writes bits 15-0 to first
// - dual store writes bits 31-16 to second
// - dual and low pair stores may repeat
// - low pair: selected low word, next low
// - pair store bypasses arithmetic, shifter, macs
// - pair store needs even accumulator zero or two
// - pair stores take selected and next accumulator
// - long word halves at address and address+1
// - word, high byte, low byte single-cycle stores
module acst_store_dp (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire acst_pkg::acst_apb_req_type apb_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    input wire acst_pkg::acst_accs_type acc_i,
    output acst_pkg::acst_mem_type mem_a_o,
    output acst_pkg::acst_mem_type mem_b_o
);
    import acst_pkg::*;

    acst_state_type s_ff;
    acst_state_type nxt_s;
    logic [ACC_W-1:0] src;
    logic [ACC_W-1:0] pair_src;
    logic [ACC_W-1:0] sat_res;
    logic sat_ovf;
    logic busy;
    logic setup;
    logic wr_acc;
    logic is_pair;
    logic is_long;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // one write beat on a memory port
    function automatic acst_mem_type beat(
        input logic [ADDR_W-1:0] addr,
        input logic [15:0] data,
        input logic [1:0] be
    );
        acst_mem_type m;
        m.we = 1'b1;
        m.addr = addr;
        m.data = data;
        m.be = be;
        return m;
    endfunction

    // operand taps straight off the accumulators
    assign src = acc_i[s_ff.acc];
    assign pair_src = acc_i[{s_ff.acc[1], 1'b1}];
    assign busy = s_ff.st == ST_RUN;
    assign setup = apb_i.psel & ~apb_i.penable;
    assign wr_acc = apb_i.psel & apb_i.penable & apb_i.pwrite & s_ff.pready & ~s_ff.pslverr;
    assign is_pair = s_ff.op == OP_PAIRHI || s_ff.op == OP_PAIRLO;
    assign is_long = is_pair || s_ff.op == OP_LONG || s_ff.op == OP_SATLONG;

    // ----------------------------------------
    // shifter path of the saturating store
    // ----------------------------------------
    acst_sat_unit u_sat (
        .acc_i(src),
        .uns_i(s_ff.uns),
        .sat_i(s_ff.sat),
        .legacy_i(s_ff.legacy),
        .sst_i(s_ff.store_saturate_enable),
        .sign_extension_mode_i(s_ff.sign_extension_mode),
        .res_o(sat_res),
        .ovf_o(sat_ovf)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.mem_a.we = 1'b0;
        nxt_s.mem_b.we = 1'b0;
        nxt_s.pready = 1'b0;
        nxt_s.pslverr = 1'b0;

        // apb setup: prepare answer for the access phase
        if (setup) begin
            nxt_s.pready = 1'b1;
            nxt_s.prdata = '0;
            case (apb_i.paddr)
                OFF_CTRL: begin
                    nxt_s.prdata[CTRL_LEG] = s_ff.legacy;
                    nxt_s.prdata[CTRL_SST] = s_ff.store_saturate_enable;
                    nxt_s.prdata[CTRL_SXM] = s_ff.sign_extension_mode;
                end
                OFF_ADDRX: begin
                    nxt_s.prdata[ADDR_W-1:0] = s_ff.addr_x;
                end
                OFF_ADDRY: begin
                    nxt_s.prdata[ADDR_W-1:0] = s_ff.addr_y;
                end
                OFF_CMD: begin
                    nxt_s.prdata[CMD_OP_LSB+:3] = s_ff.op;
                    nxt_s.prdata[CMD_ACC_LSB+:2] = s_ff.acc;
                    nxt_s.prdata[CMD_UNS] = s_ff.uns;
                    nxt_s.prdata[CMD_SAT] = s_ff.sat;
                    nxt_s.prdata[CMD_REP_LSB+:REP_W] = s_ff.rep;
                    nxt_s.pslverr = apb_i.pwrite & busy;
                end
                OFF_STAT: begin
                    nxt_s.prdata[STAT_BUSY] = busy;
                    nxt_s.prdata[STAT_OVF] = s_ff.ovf;
                    nxt_s.prdata[STAT_BAD] = s_ff.bad;
                    nxt_s.prdata[STAT_CNT_LSB+:REP_W] = s_ff.rep;
                end
                default: begin
                    nxt_s.pslverr = 1'b1;
                end
            endcase
        end

        // apb write, effective at the access edge
        if (wr_acc) begin
            case (apb_i.paddr)
                OFF_CTRL: begin
                    nxt_s.legacy = apb_i.pwdata[CTRL_LEG];
                    nxt_s.store_saturate_enable = apb_i.pwdata[CTRL_SST];
                    nxt_s.sign_extension_mode = apb_i.pwdata[CTRL_SXM];
                end
                OFF_ADDRX: begin
                    nxt_s.addr_x = apb_i.pwdata[ADDR_W-1:0];
                end
                OFF_ADDRY: begin
                    nxt_s.addr_y = apb_i.pwdata[ADDR_W-1:0];
                end
                OFF_CMD: begin
                    nxt_s.op = acst_op_type'(apb_i.pwdata[CMD_OP_LSB+:3]);
                    nxt_s.acc = apb_i.pwdata[CMD_ACC_LSB+:2];
                    nxt_s.uns = apb_i.pwdata[CMD_UNS];
                    nxt_s.sat = apb_i.pwdata[CMD_SAT];
                    nxt_s.rep = apb_i.pwdata[CMD_REP_LSB+:REP_W];
                    nxt_s.st = ST_RUN;
                end
                OFF_STAT: begin
                    // write one to clear; a new event below wins
                    if (apb_i.pwdata[STAT_OVF]) begin
                        nxt_s.ovf = 1'b0;
                    end
                    if (apb_i.pwdata[STAT_BAD]) begin
                        nxt_s.bad = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // one store beat per enabled cycle; only memory ports are written
        case (s_ff.st)
            ST_IDLE: begin
            end
            ST_RUN: begin
                case (s_ff.op)
                    OP_WORD: begin
                        nxt_s.mem_a = beat(s_ff.addr_x, src[15:0], BE_WORD);
                    end
                    OP_HIBYTE: begin
                        nxt_s.mem_a = beat(s_ff.addr_x, {src[7:0], 8'h00}, BE_HI);
                    end
                    OP_LOBYTE: begin
                        nxt_s.mem_a = beat(s_ff.addr_x, {8'h00, src[7:0]}, BE_LO);
                    end
                    OP_LONG: begin
                        nxt_s.mem_a = beat(s_ff.addr_x, src[31:16], BE_WORD);
                        nxt_s.mem_b = beat(s_ff.addr_x + STEP_ONE, src[15:0], BE_WORD);
                    end
                    OP_SATLONG: begin
                        // clamped value from the shifter path
                        nxt_s.mem_a = beat(s_ff.addr_x, sat_res[31:16], BE_WORD);
                        nxt_s.mem_b = beat(s_ff.addr_x + STEP_ONE, sat_res[15:0], BE_WORD);
                        if (sat_ovf) begin
                            nxt_s.ovf = 1'b1;
                        end
                    end
                    OP_DUAL: begin
                        nxt_s.mem_a = beat(s_ff.addr_x, src[15:0], BE_WORD);
                        nxt_s.mem_b = beat(s_ff.addr_y, src[31:16], BE_WORD);
                    end
                    OP_PAIRHI, OP_PAIRLO: begin
                        // direct path, no shifter or alu involved
                        if (s_ff.acc[0]) begin
                            nxt_s.bad = 1'b1;
                        end else if (s_ff.op == OP_PAIRHI) begin
                            nxt_s.mem_a = beat(s_ff.addr_x, src[31:16], BE_WORD);
                            nxt_s.mem_b = beat(s_ff.addr_x + STEP_ONE, pair_src[31:16], BE_WORD);
                        end else begin
                            nxt_s.mem_a = beat(s_ff.addr_x, src[15:0], BE_WORD);
                            nxt_s.mem_b = beat(s_ff.addr_x + STEP_ONE, pair_src[15:0], BE_WORD);
                        end
                    end
                    default: begin
                    end
                endcase
                // repeat with address post-increment
                if (s_ff.rep == '0 || (is_pair && s_ff.acc[0])) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.rep = '0;
                end else begin
                    nxt_s.rep = s_ff.rep - 1'b1;
                    nxt_s.addr_x = s_ff.addr_x + (is_long ? STEP_TWO : STEP_ONE);
                    nxt_s.addr_y = s_ff.addr_y + STEP_ONE;
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // state register, frozen while ce_i is low
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s_ff <= '0;
            s_ff.st <= ST_IDLE;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign pready_o = s_ff.pready;
    assign pslverr_o = s_ff.pslverr;
    assign prdata_o = s_ff.prdata;
    assign mem_a_o = s_ff.mem_a;
    assign mem_b_o = s_ff.mem_b;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    logic run_sat;
    logic run_op;
    logic [31:0] stored;
    assign run_op = ce_i && busy;
    assign run_sat = run_op && s_ff.op == OP_SATLONG;
    assign stored = {s_ff.mem_a.data, s_ff.mem_b.data};

    a_uns_clamp: assert property (
        run_sat && s_ff.uns && s_ff.sat && |src[39:32] |=> stored == SAT_UNS[31:0])
        else $error("unsigned clamp value wrong");
    a_pos_clamp: assert property (
        run_sat && !s_ff.uns && s_ff.sat && !s_ff.legacy && !src[39] && |src[38:31]
        |=> stored == SAT_POS[31:0])
        else $error("positive clamp value wrong");
    a_neg_clamp: assert property (
        run_sat && !s_ff.uns && s_ff.sat && !s_ff.legacy && src[39] && !(&src[38:31])
        |=> stored == SAT_NEG[31:0])
        else $error("negative clamp value wrong");
    a_legacy_force: assert property (
        run_sat && s_ff.legacy && s_ff.store_saturate_enable && !s_ff.sign_extension_mode && !s_ff.uns && !s_ff.sat
        && |src[39:32] |=> stored == SAT_UNS[31:0])
        else $error("legacy forcing not applied");
    a_no_qual: assert property (
        run_sat && !s_ff.sat && !(s_ff.legacy && s_ff.store_saturate_enable)
        |=> stored == $past(src[31:0]))
        else $error("value altered without saturate");
    a_dual_halves: assert property (
        run_op && s_ff.op == OP_DUAL |=> s_ff.mem_a.we && s_ff.mem_b.we
        && s_ff.mem_a.data == $past(src[15:0]) && s_ff.mem_b.data == $past(src[31:16]))
        else $error("dual store halves wrong");
    a_pair_low: assert property (
        run_op && s_ff.op == OP_PAIRLO && !s_ff.acc[0]
        |=> s_ff.mem_a.data == $past(src[15:0]) && s_ff.mem_b.data == $past(pair_src[15:0]))
        else $error("low pair store wrong");
    a_pair_odd: assert property (
        run_op && is_pair && s_ff.acc[0]
        |=> !s_ff.mem_a.we && !s_ff.mem_b.we && s_ff.bad && s_ff.st == ST_IDLE)
        else $error("odd pair not refused");
    a_long_addr: assert property (
        run_op && is_long && !(is_pair && s_ff.acc[0])
        |=> s_ff.mem_b.addr == s_ff.mem_a.addr + STEP_ONE)
        else $error("long halves not adjacent");
    a_apb_ready: assert property (
        ce_i && setup |=> s_ff.pready ##1 !s_ff.pready || !ce_i)
        else $error("apb answer timing wrong");

    c_sat_ovf: cover property (run_sat && sat_ovf && s_ff.sat);
    c_dual_rep: cover property (run_op && s_ff.op == OP_DUAL && s_ff.rep != '0);
    c_pair_bad: cover property (run_op && is_pair && s_ff.acc[0]);
    c_legacy: cover property (run_sat && s_ff.legacy && s_ff.store_saturate_enable);
endmodule

// >>> tb/acst_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// data memory behind both store ports
// ----------------------------------------
module acst_mem_model (
    input wire logic core_clk_i,
    input wire acst_pkg::acst_mem_type mem_a_i,
    input wire acst_pkg::acst_mem_type mem_b_i,
    output int beats_o,
    output logic both_o
);
    import acst_pkg::*;
    logic [15:0] mem [0:1023];

    // byte-lane write, untouched lanes keep old content
    task automatic put(input acst_mem_type m);
        if (m.be[1]) begin
            mem[m.addr[9:0]][15:8] = m.data[15:8];
        end
        if (m.be[0]) begin
            mem[m.addr[9:0]][7:0] = m.data[7:0];
        end
    endtask

    // fill with a marker so untouched words are visible
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 16'h5A5A;
        end
        beats_o = 0;
        both_o = 1'b0;
    end

    // take each beat, note beats that hit both ports together
    always @(posedge core_clk_i) begin
        if (mem_a_i.we === 1'b1) begin
            put(mem_a_i);
        end
        if (mem_b_i.we === 1'b1) begin
            put(mem_b_i);
        end
        // both_o tells whether the latest beat hit both ports together
        if (mem_a_i.we === 1'b1 || mem_b_i.we === 1'b1) begin
            beats_o++;
            both_o = mem_a_i.we === 1'b1 && mem_b_i.we === 1'b1;
        end
    end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
    import acst_pkg::*;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    acst_apb_req_type apb_i = '0;
    acst_accs_type acc_i = '0;
    logic pready_o;
    logic pslverr_o;
    logic [31:0] prdata_o;
    acst_mem_type mem_a_o;
    acst_mem_type mem_b_o;
    int beats;
    logic both;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    int b0;

    acst_store_dp acst_store_dp_i (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .apb_i(apb_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
        .acc_i(acc_i), .mem_a_o(mem_a_o), .mem_b_o(mem_b_o));
    acst_mem_model acst_mem_model_i (.core_clk_i(core_clk_i), .mem_a_i(mem_a_o),
        .mem_b_i(mem_b_o), .beats_o(beats), .both_o(both));

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_of_test;
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask

    // one apb transfer; answer taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk_i);
        apb_i.penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        apb_i <= '0;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_STAT, 32'h0);
            n++;
        end while (rd[STAT_BUSY] !== 1'b0 && n < 60);
        check("idle", {31'h0, rd[STAT_BUSY]}, 32'h0);
        @(posedge core_clk_i);
    endtask

    task automatic run(input logic [2:0] op, input logic [1:0] a, input logic u, input logic s,
        input logic [7:0] rep, input logic [23:0] x);
        apb(1'b1, OFF_ADDRX, {8'h0, x});
        apb(1'b1, OFF_CMD, {16'h0, rep, 1'b0, s, u, a, op});
        check("cmd_err", {31'h0, err}, 32'h0);
        wait_idle();
    endtask

    task automatic mchk(input string name, input int ad, input logic [15:0] exp);
        check(name, {16'h0, acst_mem_model_i.mem[ad]}, {16'h0, exp});
    endtask

    task automatic sat_case(input logic [2:0] ctrl, input logic [39:0] v, input logic u,
        input logic s, input logic [31:0] exp);
        apb(1'b1, OFF_CTRL, {29'h0, ctrl});
        acc_i[0] <= v;
        run(OP_SATLONG, 2'h0, u, s, 8'h0, 24'h000040);
        mchk("sat_hi", 64, exp[31:16]);
        mchk("sat_lo", 65, exp[15:0]);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge core_clk_i);
        srst_i <= 1'b0;
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl_rst", rd, 32'h0);
        apb(1'b0, OFF_STAT, 32'h0);
        check("stat_rst", rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_rd", rd, 32'h0);
        // saturating long store qualifier and mode table
        sat_case(3'h0, 40'h01_0000_0000, 1'b0, 1'b1, 32'h7FFF_FFFF);
        sat_case(3'h0, 40'hFE_0000_0000, 1'b0, 1'b1, 32'h8000_0000);
        sat_case(3'h0, 40'h01_2345_6789, 1'b1, 1'b1, 32'hFFFF_FFFF);
        sat_case(3'h0, 40'hFF_FFFF_FFFE, 1'b1, 1'b1, 32'hFFFF_FFFF);
        sat_case(3'h0, 40'hFF_FFFF_FFFE, 1'b0, 1'b1, 32'hFFFF_FFFE);
        sat_case(3'h0, 40'h01_2345_6789, 1'b0, 1'b0, 32'h2345_6789);
        sat_case(3'h2, 40'h01_2345_6789, 1'b0, 1'b0, 32'h2345_6789);
        sat_case(3'h3, 40'h01_2345_6789, 1'b0, 1'b0, 32'hFFFF_FFFF);
        sat_case(3'h3, 40'h00_8000_0000, 1'b0, 1'b0, 32'h8000_0000);
        sat_case(3'h7, 40'h00_8000_0000, 1'b0, 1'b0, 32'h7FFF_FFFF);
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl_keep", rd, 32'h7);
        apb(1'b0, OFF_STAT, 32'h0);
        check("ovf_flag", {31'h0, rd[STAT_OVF]}, 32'h1);
        apb(1'b1, OFF_STAT, 32'h0000_0002);
        apb(1'b0, OFF_STAT, 32'h0);
        check("ovf_clear", {31'h0, rd[STAT_OVF]}, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        acc_i <= {40'h7F_CCCC_DDDD, 40'h01_4500_0030, 40'h11_AAAA_BBBB, 40'h23_0400_6500};
        // single-register stores
        run(OP_WORD, 2'h0, 1'b0, 1'b0, 8'h0, 24'h000100);
        mchk("word", 256, 16'h6500);
        run(OP_HIBYTE, 2'h1, 1'b0, 1'b0, 8'h0, 24'h000101);
        mchk("hibyte", 257, 16'hBB5A);
        run(OP_LOBYTE, 2'h3, 1'b0, 1'b0, 8'h0, 24'h000102);
        mchk("lobyte", 258, 16'h5ADD);
        run(OP_LONG, 2'h2, 1'b0, 1'b0, 8'h0, 24'h000110);
        mchk("long_hi", 272, 16'h4500);
        mchk("long_lo", 273, 16'h0030);
        // dual store, repeated three times
        apb(1'b1, OFF_ADDRY, 32'h0000_0130);
        b0 = beats;
        run(OP_DUAL, 2'h2, 1'b0, 1'b0, 8'h2, 24'h000120);
        check("dual_beats", beats - b0, 32'h3);
        check("dual_both", {31'h0, both}, 32'h1);
        mchk("dual_x", 290, 16'h0030);
        mchk("dual_y", 306, 16'h4500);
        apb(1'b0, OFF_ADDRX, 32'h0);
        check("dual_addrx", rd, 32'h0000_0122);
        // pair stores
        run(OP_PAIRHI, 2'h0, 1'b0, 1'b0, 8'h0, 24'h000140);
        mchk("pairhi_hi", 320, 16'h0400);
        mchk("pairhi_lo", 321, 16'hAAAA);
        run(OP_PAIRLO, 2'h2, 1'b0, 1'b0, 8'h1, 24'h000150);
        mchk("pairlo_hi", 338, 16'h0030);
        mchk("pairlo_lo", 339, 16'hDDDD);
        run(OP_PAIRLO, 2'h1, 1'b0, 1'b0, 8'h0, 24'h000160);
        mchk("pair_odd", 352, 16'h5A5A);
        apb(1'b0, OFF_STAT, 32'h0);
        check("odd_flag", {31'h0, rd[STAT_BAD]}, 32'h1);
        apb(1'b1, OFF_STAT, 32'h0000_0004);
        apb(1'b0, OFF_STAT, 32'h0);
        check("odd_clear", {31'h0, rd[STAT_BAD]}, 32'h0);
        // command refused while a dual repeat runs
        apb(1'b1, OFF_ADDRX, 32'h0000_0170);
        apb(1'b1, OFF_CMD, 32'h0000_0715);
        apb(1'b1, OFF_CMD, 32'h0000_0000);
        check("busy_err", {31'h0, err}, 32'h1);
        // freeze the repeat for a few cycles; words 368 and 375 and the final address must still be right
        ce_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        ce_i <= 1'b1;
        wait_idle();
        mchk("busy_keep", 368, 16'h0030);
        mchk("busy_last", 375, 16'h0030);
        apb(1'b0, OFF_CMD, 32'h0);
        check("busy_cmd", rd, 32'h0000_0015);
        apb(1'b0, OFF_ADDRX, 32'h0);
        check("busy_addrx", rd, 32'h0000_0177);
        end_of_test();
    end
endmodule
